// ### logic/qword_multishift_byte_select.sv
// Purpose: packed qword multishift byte select, one-cycle datapath
// Assumes: operands arrive already fetched; result goes to writeback
// Notes:   result registered one cycle after the request
//
// Summary of operation
// RQ1 - eight output bytes from each data qword
// RQ2 - control byte j, low six bits
// RQ3 - field starts on any bit position
// RQ4 - bit k from (ctrl+k) mod 64
// RQ5 - 128, 256 and 512 bit lengths
// RQ6 - control from register, data three ways
// RQ7 - broadcast from memory uses element zero
// RQ8 - byte written when mask bit set
// RQ9 - zeroing clears unmasked bytes
// RQ10 - no floating-point exception raised
// RQ11 - merge keeps byte; bits above length cleared
`timescale 1ns/10ps

module qword_multishift_byte_select
(
   // clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST_N,
   // operation request
   input  wire mshift_pkg::op_req_t  REQ,
   // result
   output mshift_pkg::op_rsp_t       RSP,
   output logic [3:0]                ELEMENT_COUNT,
   output logic [2:0]                EXCEPTION_CLASS_CODE
);

   localparam int EB = mshift_pkg::ELEM_BITS;
   localparam int BB = mshift_pkg::BYTE_BITS;
   localparam int NB = mshift_pkg::BYTES_PER_EL;
   localparam int NE = mshift_pkg::MAX_ELEMS;
   localparam int VW = mshift_pkg::MAXIMUM_VECTOR_LENGTH_BITS;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [3:0] elems_of(input mshift_pkg::vec_len_t v);
      case (v)
         mshift_pkg::VL_128: elems_of = mshift_pkg::ELEMS_128;
         mshift_pkg::VL_256: elems_of = mshift_pkg::ELEMS_256;
         mshift_pkg::VL_512: elems_of = mshift_pkg::ELEMS_512;
         default:            elems_of = mshift_pkg::ELEMS_512;
      endcase
   endfunction

   // rotate right and take the low byte
   function automatic logic [7:0] pick_field(input logic [63:0] d,
                                             input logic [7:0]  c);
      logic [5:0]   sh;
      logic [127:0] dd;
      sh = c[5:0] & mshift_pkg::CTRL_MASK[5:0];                    // RQ2
      dd = {d, d} >> sh;                                            // RQ4
      pick_field = dd[7:0];                                         // RQ3
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // datapath

   logic [3:0]    n_elems;
   logic [VW-1:0] data_sel;
   logic [VW-1:0] sel_res;
   logic [VW-1:0] result_nxt;
   logic [VW-1:0] result_r;
   logic          valid_nxt;
   logic          valid_r;
   logic          use_bcast;

   always_comb
   begin
      n_elems   = elems_of(REQ.vlen);                               // RQ5
      use_bcast = REQ.bcast_bit &&
                  (REQ.kind != mshift_pkg::SRC_REG);                // RQ7
      data_sel  = (REQ.kind == mshift_pkg::SRC_REG) ? REQ.data_reg
                                                   : REQ.data_mem;  // RQ6
   end

   genvar gi;
   genvar gj;
   generate
      for (gi = 0; gi < NE; gi++)
      begin : g_el
         logic [EB-1:0] tcur;
         assign tcur = use_bcast ? data_sel[EB-1:0]
                                 : data_sel[gi*EB +: EB];           // RQ7
         for (gj = 0; gj < NB; gj++)
         begin : g_by
            localparam int P = gi*EB + gj*BB;
            logic [7:0] res;
            logic       wr;
            logic [7:0] byte_val;
            assign res = pick_field(tcur, REQ.ctrl_src[P +: BB]);   // RQ1
            assign wr  = !REQ.mask_en ||
                         REQ.byte_write_mask[gi*NB + gj];           // RQ8
            always_comb
            begin
               if (gi >= int'(n_elems))
                  byte_val = 8'h00;                                 // RQ11
               else if (wr)
                  byte_val = res;                                   // RQ8
               else if (REQ.zeroing)
                  byte_val = 8'h00;                                 // RQ9
               else
                  byte_val = REQ.dest_old[P +: BB];                 // RQ11
            end
            assign sel_res[P +: BB] = byte_val;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // result register

   logic [3:0] count_nxt;
   logic [3:0] count_r;

   always_comb
   begin
      valid_nxt  = REQ.valid;
      count_nxt  = REQ.valid ? n_elems : count_r;
      result_nxt = REQ.valid ? sel_res : result_r;
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         valid_r  <= 1'b0;
         result_r <= '0;
         count_r  <= 4'h0;
      end
      else
      begin
         valid_r <= valid_nxt;
         count_r  <= count_nxt;
         result_r <= result_nxt;
      end
   end

   assign RSP.valid            = valid_r;
   assign RSP.result           = result_r;
   assign RSP.fp_exc           = 1'b0;                              // RQ10
   assign ELEMENT_COUNT        = count_r;
   assign EXCEPTION_CLASS_CODE = mshift_pkg::EXC_CLASS_NF;          // RQ10

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_no_fp_exc;
      @(posedge CORE_CLK) disable iff (!RST_N)
      RSP.fp_exc == 1'b0;
   endproperty
   a_no_fp_exc: assert property (p_no_fp_exc)                       // RQ10
      else $error("fp exception raised");

   property p_valid_follows;
      @(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid |=> RSP.valid;
   endproperty
   a_valid_follows: assert property (p_valid_follows)               // RQ1
      else $error("result valid missing");

   property p_byte0;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && !REQ.mask_en && REQ.kind == mshift_pkg::SRC_REG)
      |=> RSP.result[0] == $past(REQ.data_reg[REQ.ctrl_src[5:0]]) &&
          RSP.result[7] ==
          $past(REQ.data_reg[6'(REQ.ctrl_src[5:0] + 6'h07)]);
   endproperty
   a_byte0: assert property (p_byte0)                               // RQ4
      else $error("byte zero field wrong");

   property p_upper_zero_128;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.vlen == mshift_pkg::VL_128)
      |=> RSP.result[VW-1:128] == '0;
   endproperty
   a_upper_zero_128: assert property (p_upper_zero_128)             // RQ11
      else $error("bits above length not cleared");

   property p_zeroing;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.mask_en && REQ.zeroing && !REQ.byte_write_mask[0])
      |=> RSP.result[7:0] == 8'h00;
   endproperty
   a_zeroing: assert property (p_zeroing)                           // RQ9
      else $error("zeroing byte not cleared");

   property p_merge;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.mask_en && !REQ.zeroing && !REQ.byte_write_mask[0])
      |=> RSP.result[7:0] == $past(REQ.dest_old[7:0]);
   endproperty
   a_merge: assert property (p_merge)                               // RQ11
      else $error("merged byte changed");

   property p_bcast;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.bcast_bit && REQ.kind != mshift_pkg::SRC_REG &&
       !REQ.mask_en && REQ.vlen == mshift_pkg::VL_512)
      |=> RSP.result[504] ==
          $past(REQ.data_mem[REQ.ctrl_src[509:504]]);
   endproperty
   a_bcast: assert property (p_bcast)                               // RQ7
      else $error("broadcast element wrong");

   property p_count;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.vlen == mshift_pkg::VL_256)
      |=> ELEMENT_COUNT == mshift_pkg::ELEMS_256;
   endproperty
   a_count: assert property (p_count)                               // RQ5
      else $error("element count wrong");

   property p_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !REQ.valid |=> $stable(RSP.result);
   endproperty
   a_hold: assert property (p_hold)                                 // RQ8
      else $error("result changed without request");

   ////////////////////////////////////////////////////////////////////////
   // spot checks on the valid pulse, single bits, bytes, upper bits and counts, independent of the field function

   property p_valid_pulse;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !REQ.valid |=> !RSP.valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse)                   // RQ1
      else $error("result valid without request");

   property p_write_b1;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.mask_en && REQ.byte_write_mask[1] &&
       REQ.kind == mshift_pkg::SRC_REG)
      |=> RSP.result[8] == $past(REQ.data_reg[REQ.ctrl_src[13:8]]);
   endproperty
   a_write_b1: assert property (p_write_b1)                         // RQ8
      else $error("masked-in byte not written");

   property p_mem_full;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.kind == mshift_pkg::SRC_MEM && !REQ.bcast_bit &&
       (!REQ.mask_en || REQ.byte_write_mask[12]))
      |=> RSP.result[96] ==
          $past(REQ.data_mem[64 + REQ.ctrl_src[101:96]]);
   endproperty
   a_mem_full: assert property (p_mem_full)                         // RQ6
      else $error("memory element one wrong");

   property p_reg_elem;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.kind == mshift_pkg::SRC_REG &&
       (!REQ.mask_en || REQ.byte_write_mask[12]))
      |=> RSP.result[96] ==
          $past(REQ.data_reg[64 + REQ.ctrl_src[101:96]]);
   endproperty
   a_reg_elem: assert property (p_reg_elem)                         // RQ7
      else $error("register element one wrong");

   property p_zero_hi;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.mask_en && REQ.zeroing && !REQ.byte_write_mask[62])
      |=> RSP.result[503:496] == 8'h00;
   endproperty
   a_zero_hi: assert property (p_zero_hi)                           // RQ9
      else $error("upper zeroing byte not cleared");

   property p_upper_zero_256;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.vlen == mshift_pkg::VL_256)
      |=> RSP.result[VW-1:256] == '0;
   endproperty
   a_upper_zero_256: assert property (p_upper_zero_256)             // RQ11
      else $error("bits above 256 not cleared");

   property p_count_128;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.vlen == mshift_pkg::VL_128)
      |=> ELEMENT_COUNT == mshift_pkg::ELEMS_128;
   endproperty
   a_count_128: assert property (p_count_128)                       // RQ5
      else $error("element count wrong for 128");

   property p_count_512;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (REQ.valid && REQ.vlen == mshift_pkg::VL_512)
      |=> ELEMENT_COUNT == mshift_pkg::ELEMS_512;
   endproperty
   a_count_512: assert property (p_count_512)                       // RQ5
      else $error("element count wrong for 512");

   property p_count_hold;
      @(posedge CORE_CLK) disable iff (!RST_N)
      !REQ.valid |=> $stable(ELEMENT_COUNT);
   endproperty
   a_count_hold: assert property (p_count_hold)                     // RQ5
      else $error("element count changed without request");

   c_zeroing: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid && REQ.mask_en && REQ.zeroing);
   c_bcast: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid && use_bcast);
   c_wrap: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid && REQ.ctrl_src[5:0] > 6'h38);
   c_vl128: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid && REQ.vlen == mshift_pkg::VL_128);
   c_merge: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
      REQ.valid && REQ.mask_en && !REQ.zeroing);

endmodule // qword_multishift_byte_select

// ### logic/mshift_pkg.sv
// Purpose: shared constants and carriers for the byte-select datapath
// Assumes: 64-bit elements, up to 512-bit vectors
// Notes:   vector length codes are one-hot
package mshift_pkg;

   localparam int ELEM_BITS     = 64;
   localparam int BYTE_BITS     = 8;
   localparam int BYTES_PER_EL  = 8;
   localparam int MAX_ELEMS     = 8;
   localparam int MAXIMUM_VECTOR_LENGTH_BITS   = 512;
   localparam int MASK_BITS     = MAX_ELEMS * BYTES_PER_EL;
   localparam int CTRL_BITS     = 6;
   localparam logic [7:0] CTRL_MASK = 8'h3F;

   // vector length select
   typedef enum logic [2:0]
   {
      VL_128 = 3'h1,
      VL_256 = 3'h2,
      VL_512 = 3'h4
   } vec_len_t;

   localparam logic [3:0] ELEMS_128 = 4'h2;
   localparam logic [3:0] ELEMS_256 = 4'h4;
   localparam logic [3:0] ELEMS_512 = 4'h8;

   // exception class marker; value arbitrary, no floating-point class
   localparam logic [2:0] EXC_CLASS_NF = 3'h4;

   // data source kind
   typedef enum logic [2:0]
   {
      SRC_REG   = 3'h1,
      SRC_MEM   = 3'h2,
      SRC_BCAST = 3'h4
   } src_kind_t;

   typedef struct packed
   {
      logic                   valid;
      vec_len_t               vlen;
      src_kind_t              kind;
      logic                   bcast_bit;
      logic                   mask_en;
      logic                   zeroing;
      logic [MASK_BITS-1:0]   byte_write_mask;
      logic [MAXIMUM_VECTOR_LENGTH_BITS-1:0] ctrl_src;
      logic [MAXIMUM_VECTOR_LENGTH_BITS-1:0] data_reg;
      logic [MAXIMUM_VECTOR_LENGTH_BITS-1:0] data_mem;
      logic [MAXIMUM_VECTOR_LENGTH_BITS-1:0] dest_old;
   } op_req_t;

   typedef struct packed
   {
      logic                   valid;
      logic [MAXIMUM_VECTOR_LENGTH_BITS-1:0] result;
      logic                   fp_exc;
   } op_rsp_t;

endpackage

// ### tb/wb_model.sv
// Purpose: writeback side model holding the destination register
// Assumes: result is taken on the edge where the response is valid
// Notes:   feeds the held value back as the old destination
`timescale 1ns/10ps

module wb_model
(
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // response from datapath
   input  wire mshift_pkg::op_rsp_t  rsp,
   // held destination
   output logic [511:0]              dest_q
);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dest_q <= 512'h0;
      else if (rsp.valid)
         dest_q <= rsp.result;
   end
endmodule // wb_model

// ### tb/qword_multishift_byte_select_tb.sv
// Purpose: self-checking bench for the byte-select datapath
// Assumes: one-cycle answer, no back-pressure
// Notes:   expected results come from a bench reference function
`timescale 1ns/10ps

module qword_multishift_byte_select_tb;
   logic                 CORE_CLK;
   logic                 RST_N;
   mshift_pkg::op_req_t  REQ;
   mshift_pkg::op_rsp_t  RSP;
   logic [3:0]           ELEMENT_COUNT;
   logic [2:0]           EXCEPTION_CLASS_CODE;
   logic [511:0]         wb_q;
   int                   n_fail;
   int                   comparisons;

   qword_multishift_byte_select qword_multishift_byte_select_inst
   (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .REQ(REQ), .RSP(RSP),
    .ELEMENT_COUNT(ELEMENT_COUNT),
    .EXCEPTION_CLASS_CODE(EXCEPTION_CLASS_CODE));
   wb_model wb_model_inst
   (.clk(CORE_CLK), .rst_n(RST_N), .rsp(RSP), .dest_q(wb_q));

   initial
   begin
      CORE_CLK = 1'b0;
      forever #2 CORE_CLK = ~CORE_CLK;
   end

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [511:0] ref_res(mshift_pkg::op_req_t r);
      int n;
      int c;
      logic [63:0] t;
      logic [511:0] o;
      n = (r.vlen == mshift_pkg::VL_128) ? 2 :
          (r.vlen == mshift_pkg::VL_256) ? 4 : 8;
      o = 512'h0;
      for (int i = 0; i < n; i++)
      begin
         if (r.kind != mshift_pkg::SRC_REG && r.bcast_bit)
            t = r.data_mem[63:0];
         else if (r.kind == mshift_pkg::SRC_REG)
            t = r.data_reg[i*64 +: 64];
         else
            t = r.data_mem[i*64 +: 64];
         for (int j = 0; j < 8; j++)
         begin
            c = int'(r.ctrl_src[i*64+j*8 +: 6]);
            if (!r.mask_en || r.byte_write_mask[i*8+j])
               for (int k = 0; k < 8; k++)
                  o[i*64+j*8+k] = t[(c+k)%64];
            else if (!r.zeroing)
               o[i*64+j*8 +: 8] = r.dest_old[i*64+j*8 +: 8];
         end
      end
      return o;
   endfunction

   task automatic cmp_res(input logic [511:0] g, input logic [511:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t result %h exp %h", $time, g, e);
      end
   endtask

   task automatic cmp_small(input logic [3:0] g, input logic [3:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t field %h exp %h", $time, g, e);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // issue one op, check the one-cycle pulse and its result
   task automatic run_op(input mshift_pkg::op_req_t r, input logic [3:0] n);
      logic [511:0] e;
      r.dest_old = wb_q;
      e = ref_res(r);
      @(posedge CORE_CLK);
      REQ <= r;
      @(posedge CORE_CLK);
      REQ.valid <= 1'b0;
      #1;
      cmp_small({3'h0, RSP.valid}, 4'h1);
      cmp_res(RSP.result, e);
      cmp_small(ELEMENT_COUNT, n);
      cmp_small({3'h0, RSP.fp_exc}, 4'h0);
      cmp_small({1'b0, EXCEPTION_CLASS_CODE},
                {1'b0, mshift_pkg::EXC_CLASS_NF});
      @(posedge CORE_CLK);
      #1;
      cmp_small({3'h0, RSP.valid}, 4'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mshift_pkg::op_req_t r;
      n_fail = 0;
      comparisons = 0;
      REQ = '0;
      RST_N = 1'b0;
      repeat (16) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      #1;
      cmp_res(RSP.result, 512'h0);
      cmp_small(ELEMENT_COUNT, 4'h0);
      $display("test reset done");
      for (int v = 2; v >= 0; v--)
         for (int s = 0; s < 3; s++)
            for (int m = 0; m < 3; m++)
            begin
               r = '0;
               r.valid = 1'b1;
               r.vlen = mshift_pkg::vec_len_t'(3'h1 << v);
               r.kind = mshift_pkg::src_kind_t'(3'h1 << s);
               r.bcast_bit = (m != 2);
               r.mask_en = (m != 0);
               r.zeroing = (m == 2);
               r.byte_write_mask = 64'hA5C30F965A3CF06A;
               for (int b = 0; b < 64; b++)
                  r.ctrl_src[b*8 +: 8] = 8'(b*7 + 8'hFB);
               for (int i = 0; i < 8; i++)
               begin
                  r.data_reg[i*64 +: 64] = 64'h0123456789ABCDEF ^ 64'(i*9);
                  r.data_mem[i*64 +: 64] = 64'hF0E1D2C3B4A59687 + 64'(i);
               end
               run_op(r, 4'(2 << v));
            end
      $display("test modes done");
      @(posedge CORE_CLK);
      RST_N <= 1'b0;
      @(posedge CORE_CLK);
      #1;
      cmp_res(RSP.result, 512'h0);
      cmp_small(ELEMENT_COUNT, 4'h0);
      cmp_small({3'h0, RSP.valid}, 4'h0);
      @(posedge CORE_CLK);
      RST_N <= 1'b1;
      run_op(r, 4'h2);
      $display("test mid reset done");
      report_and_stop();
   end

   initial
   begin
      #(4 * 2000);
      n_fail++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      report_and_stop();
   end
endmodule // qword_multishift_byte_select_tb
